// *** core/rtr_pkg.sv ***
/*
 Package for the regulator tuning register bank: command codes, field layout,
 power-up defaults and writable-bit masks. Assumes a single 100 MHz clock domain.
*/
package rtr_pkg;
    localparam logic [7:0] CMD_LOAD_LINE = 8'hD8;
    localparam logic [7:0] CMD_TRANSIENT = 8'hD9;
    localparam logic [7:0] CMD_MAX_CURRENT = 8'hDA;
    localparam logic [7:0] CMD_BOOT_VOLTAGE = 8'hDB;
    localparam logic [7:0] CMD_FREQ_SOFTSTART = 8'hDC;
    localparam logic [7:0] CMD_SLEW_MODES = 8'hDD;

    localparam logic [7:0] NV_LOAD_LINE = 8'h04;
    localparam logic [7:0] NV_TRANSIENT = 8'h77;
    localparam logic [7:0] NV_BOOT_VOLTAGE = 8'h97;
    localparam logic [7:0] NV_FREQ_SOFTSTART = 8'h20;
    localparam logic [7:0] NV_SLEW_MODES = 8'h89;

    // Writable-bit masks; cleared bits always read as zero.
    localparam logic [7:0] MASK_TRANSIENT = 8'h77;
    localparam logic [7:0] MASK_FREQ_SOFTSTART = 8'hF3;

    localparam int OSR_LSB = 0;
    localparam int USR_LSB = 4;
    localparam int FSW_LSB = 4;
    localparam int VID_SEL_BIT = 7;
    localparam logic [2:0] REDUCTION_OFF = 3'h7;
    localparam logic [7:0] PCT_NOMINAL = 8'h64;

    typedef enum logic [1:0] {
        RTR_IDLE = 2'b00,
        RTR_LOAD = 2'b01,
        RTR_RUN = 2'b10
    } rtr_state_t;
endpackage

// *** core/rtr_bank.sv ***
/*
 Regulator tuning register bank: six byte commands reached by command code,
 with strap or non-volatile power-up values and decoded settings for the loop.
 Assumes the command port is already decoded from the management bus and that
 strap levels are stable and synchronous to i_clock.
*/
// Contract
// - Droop code decodes to load-line percent.
// - Transient command holds two 3-bit thresholds.
// - Undershoot codes give millivolts, 111 disables.
// - Overshoot codes give millivolts, 111 disables.
// - Host write overrides strap; bits 7,3 zero.
// - Transient non-volatile default is 77h.
// - Eight-bit max operating current, host writable.
// - Host max current write beats strap value.
// - Boot code read via selected ident table.
// - Boot write overrides strap; default 97h.
// - Frequency 7:4, rise 1:0, bits 3:2 zero.
// - Frequency field decodes to kilohertz.
// - Rise field divides slew by 1..8.
// - Freq write overrides strap; default 20h.
// - Slew/mode write overrides strap; default 89h.
// - Slew code 000..111 selects output slew.
// - Bit 7 selects voltage ident table.
`timescale 1ns/1ps
`default_nettype none
module rtr_bank (
    input wire logic i_clock, // 100 MHz clock
    input wire logic i_rst_b, // asynchronous reset, active low
    input wire logic i_clk_en, // freezes all state while low
    input wire logic i_use_strap, // power-up source: 1 strap, 0 store
    input wire logic [7:0] i_transient_strap_pin, // decoded transient strap
    input wire logic [7:0] i_freq_current_strap_pin, // decoded max current strap
    input wire logic [7:0] i_freq_strap, // decoded frequency strap
    input wire logic [7:0] i_boot_strap, // decoded boot voltage strap
    input wire logic [7:0] i_slew_mode_strap, // decoded slew and mode strap
    input wire logic [7:0] i_nv_max_current, // stored max current value
    input wire logic i_cmd_wr, // byte write strobe
    input wire logic i_cmd_rd, // byte read strobe
    input wire logic [7:0] i_cmd_code, // command code
    input wire logic [7:0] i_cmd_wdata, // write data
    output logic [7:0] o_cmd_rdata, // read data, registered
    output logic o_cmd_rvalid, // read data valid pulse
    output logic o_cmd_ack, // command taken, one cycle
    output logic o_cmd_nack, // unknown command code, one cycle
    output logic o_ready, // power-up load complete
    output logic [7:0] o_droop_pct, // load-line percent of nominal
    output logic [7:0] o_overshoot_reduction_mv, // overshoot threshold mV
    output logic o_overshoot_reduction_en, // overshoot reduction active
    output logic [7:0] o_undershoot_reduction_mv, // undershoot threshold mV
    output logic o_undershoot_reduction_en, // undershoot reduction active
    output logic [7:0] o_max_operating_current, // amperes
    output logic [7:0] o_boot_voltage_code, // boot voltage ident code
    output logic o_vid_table_select, // 0 newer table, 1 older table
    output logic [9:0] o_switching_freq_sel, // switching frequency kHz
    output logic [1:0] o_softstart_rise_factor, // ramp shift: 2^-n of slew
    output logic [2:0] o_slew_code, // output slew code
    output logic [8:0] o_slew_rate_centi // slew in 0.01 mV/us
);
    rtr_pkg::rtr_state_t state;
    rtr_pkg::rtr_state_t next_state;
    logic [7:0] load_line_scale;
    logic [7:0] transient_reduction_thresholds;
    logic [7:0] max_current_setting;
    logic [7:0] boot_voltage_code;
    logic [7:0] switch_freq_softstart;
    logic [7:0] slew_and_modes;
    logic known;
    logic [7:0] next_rdata;
    logic cmd_go;

    assign cmd_go = i_clk_en && state == rtr_pkg::RTR_RUN;

    always_comb begin
        next_state = state;
        case (state)
            rtr_pkg::RTR_IDLE: next_state = rtr_pkg::RTR_LOAD;
            rtr_pkg::RTR_LOAD: next_state = rtr_pkg::RTR_RUN;
            rtr_pkg::RTR_RUN: next_state = rtr_pkg::RTR_RUN;
            default: next_state = rtr_pkg::RTR_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= rtr_pkg::RTR_IDLE;
        end else if (i_clk_en) begin
            state <= next_state;
        end
    end

    assign o_ready = state == rtr_pkg::RTR_RUN;

    // Strap levels are captured two cycles after reset release, never in reset.
    // power-up source
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            load_line_scale <= rtr_pkg::NV_LOAD_LINE;
            transient_reduction_thresholds <= rtr_pkg::NV_TRANSIENT;
            max_current_setting <= 8'h00;
            boot_voltage_code <= rtr_pkg::NV_BOOT_VOLTAGE;
            switch_freq_softstart <= rtr_pkg::NV_FREQ_SOFTSTART;
            slew_and_modes <= rtr_pkg::NV_SLEW_MODES;
        end else if (i_clk_en) begin
            if (state == rtr_pkg::RTR_LOAD) begin
                if (i_use_strap) begin
                    transient_reduction_thresholds <=
                        i_transient_strap_pin & rtr_pkg::MASK_TRANSIENT;
                    max_current_setting <= i_freq_current_strap_pin;
                    boot_voltage_code <= i_boot_strap;
                    switch_freq_softstart <= i_freq_strap & rtr_pkg::MASK_FREQ_SOFTSTART;
                    slew_and_modes <= i_slew_mode_strap;
                end else begin
                    max_current_setting <= i_nv_max_current;
                end
            end else if (cmd_go && i_cmd_wr) begin
                if (i_cmd_code == rtr_pkg::CMD_LOAD_LINE) begin
                    load_line_scale <= i_cmd_wdata;
                end else if (i_cmd_code == rtr_pkg::CMD_TRANSIENT) begin
                    transient_reduction_thresholds <= i_cmd_wdata & rtr_pkg::MASK_TRANSIENT;
                end else if (i_cmd_code == rtr_pkg::CMD_MAX_CURRENT) begin
                    max_current_setting <= i_cmd_wdata;
                end else if (i_cmd_code == rtr_pkg::CMD_BOOT_VOLTAGE) begin
                    boot_voltage_code <= i_cmd_wdata;
                end else if (i_cmd_code == rtr_pkg::CMD_FREQ_SOFTSTART) begin
                    switch_freq_softstart <= i_cmd_wdata & rtr_pkg::MASK_FREQ_SOFTSTART;
                end else if (i_cmd_code == rtr_pkg::CMD_SLEW_MODES) begin
                    slew_and_modes <= i_cmd_wdata;
                end
            end
        end
    end

    always_comb begin
        known = 1'b1;
        next_rdata = 8'h00;
        if (i_cmd_code == rtr_pkg::CMD_LOAD_LINE) begin
            next_rdata = load_line_scale;
        end else if (i_cmd_code == rtr_pkg::CMD_TRANSIENT) begin
            next_rdata = transient_reduction_thresholds;
        end else if (i_cmd_code == rtr_pkg::CMD_MAX_CURRENT) begin
            next_rdata = max_current_setting;
        end else if (i_cmd_code == rtr_pkg::CMD_BOOT_VOLTAGE) begin
            next_rdata = boot_voltage_code;
        end else if (i_cmd_code == rtr_pkg::CMD_FREQ_SOFTSTART) begin
            next_rdata = switch_freq_softstart;
        end else if (i_cmd_code == rtr_pkg::CMD_SLEW_MODES) begin
            next_rdata = slew_and_modes;
        end else begin
            known = 1'b0;
        end
    end

    // Unknown codes still answer, with nack and zero data, so the host never hangs.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cmd_rdata <= 8'h00;
            o_cmd_rvalid <= 1'b0;
            o_cmd_ack <= 1'b0;
            o_cmd_nack <= 1'b0;
        end else if (i_clk_en) begin
            o_cmd_rvalid <= cmd_go && i_cmd_rd && known;
            o_cmd_ack <= cmd_go && (i_cmd_rd || i_cmd_wr) && known;
            o_cmd_nack <= cmd_go && (i_cmd_rd || i_cmd_wr) && !known;
            if (cmd_go && i_cmd_rd) begin
                o_cmd_rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_droop_pct <= rtr_pkg::PCT_NOMINAL;
        end else if (i_clk_en) begin
            case (load_line_scale)
                8'h00: o_droop_pct <= 8'h00;
                8'h01: o_droop_pct <= 8'h19;
                8'h02: o_droop_pct <= 8'h32;
                8'h03: o_droop_pct <= 8'h4B;
                8'h10: o_droop_pct <= 8'h50;
                8'h20: o_droop_pct <= 8'h55;
                8'h30: o_droop_pct <= 8'h5A;
                8'h40: o_droop_pct <= 8'h5F;
                8'h50: o_droop_pct <= 8'h69;
                8'h60: o_droop_pct <= 8'h6E;
                8'h70: o_droop_pct <= 8'h73;
                8'h80: o_droop_pct <= 8'h78;
                8'h90: o_droop_pct <= 8'h7D;
                8'hA0: o_droop_pct <= 8'h96;
                8'hB0: o_droop_pct <= 8'hAF;
                default: o_droop_pct <= rtr_pkg::PCT_NOMINAL;
            endcase
        end
    end

    logic [2:0] osr_code;
    logic [2:0] usr_code;
    assign osr_code = transient_reduction_thresholds[rtr_pkg::OSR_LSB +: 3];
    assign usr_code = transient_reduction_thresholds[rtr_pkg::USR_LSB +: 3];

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_overshoot_reduction_mv <= 8'h00;
            o_overshoot_reduction_en <= 1'b0;
            o_undershoot_reduction_mv <= 8'h00;
            o_undershoot_reduction_en <= 1'b0;
        end else if (i_clk_en) begin
            o_overshoot_reduction_en <= osr_code != rtr_pkg::REDUCTION_OFF;
            o_undershoot_reduction_en <= usr_code != rtr_pkg::REDUCTION_OFF;
            case (osr_code)
                3'h0: o_overshoot_reduction_mv <= 8'h1E;
                3'h1: o_overshoot_reduction_mv <= 8'h28;
                3'h2: o_overshoot_reduction_mv <= 8'h3C;
                3'h3: o_overshoot_reduction_mv <= 8'h50;
                3'h4: o_overshoot_reduction_mv <= 8'h64;
                3'h5: o_overshoot_reduction_mv <= 8'h78;
                3'h6: o_overshoot_reduction_mv <= 8'h8C;
                default: o_overshoot_reduction_mv <= 8'h00;
            endcase
            case (usr_code)
                3'h0: o_undershoot_reduction_mv <= 8'h14;
                3'h1: o_undershoot_reduction_mv <= 8'h1E;
                3'h2: o_undershoot_reduction_mv <= 8'h3C;
                3'h3: o_undershoot_reduction_mv <= 8'h50;
                3'h4: o_undershoot_reduction_mv <= 8'h64;
                3'h5: o_undershoot_reduction_mv <= 8'h78;
                3'h6: o_undershoot_reduction_mv <= 8'h8C;
                default: o_undershoot_reduction_mv <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_switching_freq_sel <= 10'h000;
            o_slew_rate_centi <= 9'h000;
        end else if (i_clk_en) begin
            case (switch_freq_softstart[rtr_pkg::FSW_LSB +: 4])
                4'h0: o_switching_freq_sel <= 10'h12C;
                4'h1: o_switching_freq_sel <= 10'h190;
                4'h2: o_switching_freq_sel <= 10'h1F4;
                4'h3: o_switching_freq_sel <= 10'h258;
                4'h4: o_switching_freq_sel <= 10'h2BC;
                4'h5: o_switching_freq_sel <= 10'h320;
                4'h6: o_switching_freq_sel <= 10'h384;
                4'h7: o_switching_freq_sel <= 10'h3E8;
                4'h8: o_switching_freq_sel <= 10'h15E;
                4'h9: o_switching_freq_sel <= 10'h1C2;
                4'hA: o_switching_freq_sel <= 10'h226;
                4'hB: o_switching_freq_sel <= 10'h28A;
                4'hC: o_switching_freq_sel <= 10'h2EE;
                4'hD: o_switching_freq_sel <= 10'h352;
                4'hE: o_switching_freq_sel <= 10'h3B6;
                default: o_switching_freq_sel <= 10'h3E8;
            endcase
            case (slew_and_modes[2:0])
                3'h0: o_slew_rate_centi <= 9'h022;
                3'h1: o_slew_rate_centi <= 9'h044;
                3'h2: o_slew_rate_centi <= 9'h066;
                3'h3: o_slew_rate_centi <= 9'h088;
                3'h4: o_slew_rate_centi <= 9'h0AA;
                3'h5: o_slew_rate_centi <= 9'h0CC;
                3'h6: o_slew_rate_centi <= 9'h0EE;
                default: o_slew_rate_centi <= 9'h112;
            endcase
        end
    end

    assign o_max_operating_current = max_current_setting;
    assign o_boot_voltage_code = boot_voltage_code;
    assign o_vid_table_select = slew_and_modes[rtr_pkg::VID_SEL_BIT];
    assign o_softstart_rise_factor = switch_freq_softstart[1:0];
    assign o_slew_code = slew_and_modes[2:0];

    chk_transient_rsvd_zero: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        transient_reduction_thresholds[7] == 1'b0 && transient_reduction_thresholds[3] == 1'b0)
        else $error("transient reserved bits set");
    chk_freq_rsvd_zero: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        switch_freq_softstart[3:2] == 2'b00)
        else $error("frequency reserved bits set");
    chk_write_takes_max: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        cmd_go && i_cmd_wr && i_cmd_code == rtr_pkg::CMD_MAX_CURRENT
        |=> o_max_operating_current == $past(i_cmd_wdata))
        else $error("max current write lost");
    chk_write_takes_boot: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        cmd_go && i_cmd_wr && i_cmd_code == rtr_pkg::CMD_BOOT_VOLTAGE
        |=> o_boot_voltage_code == $past(i_cmd_wdata))
        else $error("boot write lost");
    chk_read_returns_slew: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        cmd_go && i_cmd_rd && i_cmd_code == rtr_pkg::CMD_SLEW_MODES
        |=> o_cmd_rvalid && o_cmd_rdata == $past(slew_and_modes))
        else $error("slew read wrong");
    chk_osr_off_disables: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_clk_en && osr_code == rtr_pkg::REDUCTION_OFF |=> !o_overshoot_reduction_en)
        else $error("overshoot not disabled");
    chk_usr_first_code: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_clk_en && usr_code == 3'h0 |=> o_undershoot_reduction_mv == 8'h14)
        else $error("undershoot 20 mV wrong");
    chk_droop_top_code: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_clk_en && load_line_scale == 8'hB0 |=> o_droop_pct == 8'hAF)
        else $error("droop 175 percent wrong");
    chk_store_default_load: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_clk_en && state == rtr_pkg::RTR_LOAD && !i_use_strap
        |=> transient_reduction_thresholds == rtr_pkg::NV_TRANSIENT
            && switch_freq_softstart == rtr_pkg::NV_FREQ_SOFTSTART)
        else $error("stored defaults not kept");
    chk_unknown_gets_nack: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        cmd_go && (i_cmd_rd || i_cmd_wr) && !known |=> o_cmd_nack && !o_cmd_ack)
        else $error("unknown code not refused");
    chk_osr_first_code: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_clk_en && osr_code == 3'h0 |=> o_overshoot_reduction_mv == 8'h1E)
        else $error("overshoot 30 mV wrong");
    chk_usr_off_disables: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_clk_en && usr_code == rtr_pkg::REDUCTION_OFF |=> !o_undershoot_reduction_en)
        else $error("undershoot not disabled");
    chk_freq_top_code: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_clk_en && switch_freq_softstart[rtr_pkg::FSW_LSB +: 4] == 4'hF
        |=> o_switching_freq_sel == 10'h3E8)
        else $error("frequency 1000 kHz wrong");
    chk_strap_boot_load: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_clk_en && state == rtr_pkg::RTR_LOAD && i_use_strap
        |=> boot_voltage_code == $past(i_boot_strap))
        else $error("boot strap not loaded");
    chk_slew_top_code: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_clk_en && slew_and_modes[2:0] == 3'h7 |=> o_slew_rate_centi == 9'h112)
        else $error("slew top code wrong");
endmodule
`default_nettype wire

// *** bench/rtr_host_model.sv ***
/*
 Host and strap model for the regulator tuning register bank: issues single byte
 commands and presents strap levels. Assumes the bank answers one cycle after taking.
*/
`timescale 1ns/1ps
`default_nettype none
module rtr_host_model (
    input wire logic i_clock, // bank clock
    input wire logic i_cmd_ack, // command taken
    input wire logic i_cmd_nack, // command refused
    input wire logic i_cmd_rvalid, // read data valid
    input wire logic [7:0] i_cmd_rdata, // read data
    output var logic o_cmd_wr, // write strobe
    output var logic o_cmd_rd, // read strobe
    output var logic [7:0] o_cmd_code, // command code
    output var logic [7:0] o_cmd_wdata, // write byte
    output var logic o_use_strap, // strap or store at power-up
    output var logic [7:0] o_transient_strap_pin, // transient strap level
    output var logic [7:0] o_freq_current_strap_pin, // max current strap level
    output var logic [7:0] o_freq_strap, // frequency strap level
    output var logic [7:0] o_boot_strap, // boot code strap level
    output var logic [7:0] o_slew_mode_strap, // slew and mode strap level
    output var logic [7:0] o_nv_max_current // stored max current
);
    initial begin
        o_cmd_wr = 1'b0;
        o_cmd_rd = 1'b0;
        o_cmd_code = 8'h00;
        o_cmd_wdata = 8'h00;
        set_straps(1'b0, 8'hAB, 8'h80, 8'hFF, 8'h3C, 8'h05, 8'h5A);
    end

    task automatic set_straps(input logic use_s, input logic [7:0] tr, input logic [7:0] fc,
        input logic [7:0] fr, input logic [7:0] bt, input logic [7:0] sl, input logic [7:0] nv);
        o_use_strap = use_s;
        o_transient_strap_pin = tr;
        o_freq_current_strap_pin = fc;
        o_freq_strap = fr;
        o_boot_strap = bt;
        o_slew_mode_strap = sl;
        o_nv_max_current = nv;
    endtask

    // one byte command per transfer, answer taken a cycle later.
    task automatic send(input logic wr, input logic [7:0] code, input logic [7:0] data,
        output logic [7:0] rdata, output logic [2:0] resp);
        @(negedge i_clock);
        o_cmd_wr = wr;
        o_cmd_rd = !wr;
        o_cmd_code = code;
        o_cmd_wdata = data;
        @(negedge i_clock);
        o_cmd_wr = 1'b0;
        o_cmd_rd = 1'b0;
        // Released lines flip so a stale value can never look like a fresh one.
        o_cmd_code = ~code;
        o_cmd_wdata = ~data;
        resp = {i_cmd_ack, i_cmd_nack, i_cmd_rvalid};
        rdata = i_cmd_rdata;
    endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
/*
 Self-checking bench for the regulator tuning register bank: store and strap power-up
 readback after reset, then table of host writes with readback and decoded outputs,
 then refusal and clock-enable cases.
 Assumes the host model drives commands and straps at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {
        logic [3:0] sel;
        logic [7:0] wdata;
        logic [15:0] dec;
    } rtr_row_t;
    logic i_clock, i_rst_b, i_clk_en, cmd_wr, cmd_rd, use_strap, rvalid, ack, nack, ready;
    logic [7:0] code, wdata, tr_s, fc_s, fr_s, bt_s, sl_s, nv_mc, rdata, droop, osr_mv, usr_mv;
    logic [7:0] max_cur, boot;
    logic osr_en, usr_en, voltage_ident_code;
    logic [9:0] freq;
    logic [1:0] rise;
    logic [2:0] slew_code;
    logic [8:0] slew_centi;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    rtr_row_t rows [0:54] = '{
        '{4'h0, 8'h00, 16'h0000}, '{4'h0, 8'h01, 16'h0019}, '{4'h0, 8'h02, 16'h0032},
        '{4'h0, 8'h03, 16'h004B}, '{4'h0, 8'h04, 16'h0064}, '{4'h0, 8'h10, 16'h0050},
        '{4'h0, 8'h20, 16'h0055}, '{4'h0, 8'h30, 16'h005A}, '{4'h0, 8'h40, 16'h005F},
        '{4'h0, 8'h50, 16'h0069}, '{4'h0, 8'h60, 16'h006E}, '{4'h0, 8'h70, 16'h0073},
        '{4'h0, 8'h80, 16'h0078}, '{4'h0, 8'h90, 16'h007D}, '{4'h0, 8'hA0, 16'h0096},
        '{4'h0, 8'hB0, 16'h00AF}, '{4'h0, 8'h05, 16'h0064}, '{4'h0, 8'hC0, 16'h0064},
        '{4'h1, 8'h00, 16'h141E}, '{4'h1, 8'h11, 16'h1E28}, '{4'h1, 8'h22, 16'h3C3C},
        '{4'h1, 8'h33, 16'h5050}, '{4'h1, 8'h44, 16'h6464}, '{4'h1, 8'h55, 16'h7878},
        '{4'h1, 8'h66, 16'h8C8C}, '{4'h2, 8'hFF, 16'h0000}, '{4'h2, 8'h70, 16'h0001},
        '{4'h2, 8'h07, 16'h0002}, '{4'h2, 8'h66, 16'h0003}, '{4'h3, 8'hA5, 16'h00A5},
        '{4'h3, 8'hFF, 16'h00FF}, '{4'h4, 8'h3C, 16'h003C}, '{4'h4, 8'hC3, 16'h00C3},
        '{4'h5, 8'h00, 16'h012C}, '{4'h5, 8'h10, 16'h0190}, '{4'h5, 8'h20, 16'h01F4},
        '{4'h5, 8'h80, 16'h015E}, '{4'h5, 8'h90, 16'h01C2}, '{4'h5, 8'hF0, 16'h03E8},
        '{4'h5, 8'hFF, 16'h03E8}, '{4'h6, 8'h01, 16'h0001}, '{4'h6, 8'h02, 16'h0002},
        '{4'h6, 8'h03, 16'h0003}, '{4'h6, 8'h00, 16'h0000}, '{4'h7, 8'h00, 16'h0022},
        '{4'h7, 8'h01, 16'h0044}, '{4'h7, 8'h02, 16'h0066}, '{4'h7, 8'h03, 16'h0088},
        '{4'h7, 8'h04, 16'h00AA}, '{4'h7, 8'h05, 16'h00CC}, '{4'h7, 8'h06, 16'h00EE},
        '{4'h7, 8'h07, 16'h0112}, '{4'h8, 8'h80, 16'h0008}, '{4'h8, 8'h07, 16'h0007},
        '{4'h8, 8'h85, 16'h000D}};
    logic [7:0] nv_exp [0:5] = '{8'h04, 8'h77, 8'h5A, 8'h97, 8'h20, 8'h89};
    logic [7:0] st_exp [0:5] = '{8'h04, 8'h23, 8'h80, 8'h3C, 8'hF3, 8'h05};
    // Command code that each row selector writes and then reads back.
    logic [7:0] sel_code [0:8] = '{rtr_pkg::CMD_LOAD_LINE, rtr_pkg::CMD_TRANSIENT,
        rtr_pkg::CMD_TRANSIENT, rtr_pkg::CMD_MAX_CURRENT, rtr_pkg::CMD_BOOT_VOLTAGE,
        rtr_pkg::CMD_FREQ_SOFTSTART, rtr_pkg::CMD_FREQ_SOFTSTART, rtr_pkg::CMD_SLEW_MODES,
        rtr_pkg::CMD_SLEW_MODES};

    rtr_bank i_rtr_bank (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
        .i_use_strap(use_strap), .i_transient_strap_pin(tr_s), .i_freq_current_strap_pin(fc_s),
        .i_freq_strap(fr_s), .i_boot_strap(bt_s), .i_slew_mode_strap(sl_s),
        .i_nv_max_current(nv_mc), .i_cmd_wr(cmd_wr), .i_cmd_rd(cmd_rd), .i_cmd_code(code),
        .i_cmd_wdata(wdata), .o_cmd_rdata(rdata), .o_cmd_rvalid(rvalid), .o_cmd_ack(ack),
        .o_cmd_nack(nack), .o_ready(ready), .o_droop_pct(droop),
        .o_overshoot_reduction_mv(osr_mv), .o_overshoot_reduction_en(osr_en),
        .o_undershoot_reduction_mv(usr_mv), .o_undershoot_reduction_en(usr_en),
        .o_max_operating_current(max_cur), .o_boot_voltage_code(boot),
        .o_vid_table_select(voltage_ident_code), .o_switching_freq_sel(freq), .o_softstart_rise_factor(rise),
        .o_slew_code(slew_code), .o_slew_rate_centi(slew_centi));
    rtr_host_model i_rtr_host_model (.i_clock(i_clock), .i_cmd_ack(ack), .i_cmd_nack(nack),
        .i_cmd_rvalid(rvalid), .i_cmd_rdata(rdata), .o_cmd_wr(cmd_wr), .o_cmd_rd(cmd_rd),
        .o_cmd_code(code), .o_cmd_wdata(wdata), .o_use_strap(use_strap),
        .o_transient_strap_pin(tr_s), .o_freq_current_strap_pin(fc_s), .o_freq_strap(fr_s),
        .o_boot_strap(bt_s), .o_slew_mode_strap(sl_s), .o_nv_max_current(nv_mc));

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic apply_reset();
        int w;
        @(negedge i_clock);
        i_rst_b = 1'b0;
        repeat (12) @(negedge i_clock);
        check({15'h0000, ready}, 16'h0000);
        i_rst_b = 1'b1;
        for (w = 0; w < 10 && ready !== 1'b1; w++) @(negedge i_clock);
        check({15'h0000, ready}, 16'h0001);
    endtask

    task automatic read_all(input logic [7:0] exp [0:5]);
        logic [7:0] rd;
        logic [2:0] resp;
        for (int k = 0; k < 6; k++) begin
            i_rtr_host_model.send(1'b0, rtr_pkg::CMD_LOAD_LINE + 8'(k), 8'h00, rd, resp);
            check({8'h00, rd}, {8'h00, exp[k]});
        end
    endtask

    function automatic logic [15:0] seen_dec(input logic [3:0] sel);
        case (sel)
            4'h0: return {8'h00, droop};
            4'h1: return {usr_mv, osr_mv};
            4'h2: return {14'h0000, usr_en, osr_en};
            4'h3: return {8'h00, max_cur};
            4'h4: return {8'h00, boot};
            4'h5: return {6'h00, freq};
            4'h6: return {14'h0000, rise};
            4'h7: return {7'h00, slew_centi};
            default: return {12'h000, voltage_ident_code, slew_code};
        endcase
    endfunction

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        logic [7:0] rd, cd, mk;
        logic [2:0] resp;
        i_rst_b = 1'b0;
        i_clk_en = 1'b1;
        apply_reset();
        read_all(nv_exp);
        check({droop, 6'h00, usr_en, osr_en}, 16'h6400);
        check({voltage_ident_code, slew_code, 2'h0, freq}, 16'h91F4);
        i_rtr_host_model.set_straps(1'b1, 8'hAB, 8'h80, 8'hFF, 8'h3C, 8'h05, 8'h5A);
        apply_reset();
        read_all(st_exp);
        foreach (rows[n]) begin
            cd = sel_code[rows[n].sel];
            mk = (cd == rtr_pkg::CMD_TRANSIENT) ? rtr_pkg::MASK_TRANSIENT :
                ((cd == rtr_pkg::CMD_FREQ_SOFTSTART) ? rtr_pkg::MASK_FREQ_SOFTSTART : 8'hFF);
            i_rtr_host_model.send(1'b1, cd, rows[n].wdata, rd, resp);
            check({13'h0000, resp}, 16'h0004);
            i_rtr_host_model.send(1'b0, cd, 8'h00, rd, resp);
            check({13'h0000, resp}, 16'h0005);
            check({8'h00, rd}, {8'h00, rows[n].wdata & mk});
            check(seen_dec(rows[n].sel), rows[n].dec);
        end
        i_rtr_host_model.send(1'b0, 8'hDE, 8'h00, rd, resp);
        check({5'h00, resp, rd}, 16'h0200);
        i_rtr_host_model.send(1'b1, 8'hD7, 8'h11, rd, resp);
        check({13'h0000, resp}, 16'h0002);
        @(negedge i_clock);
        i_clk_en = 1'b0;
        i_rtr_host_model.send(1'b1, 8'hDA, 8'h11, rd, resp);
        check({13'h0000, resp}, 16'h0000);
        i_clk_en = 1'b1;
        i_rtr_host_model.send(1'b0, 8'hDA, 8'h00, rd, resp);
        check({8'h00, rd}, 16'h00FF);
        end_of_test();
    end
endmodule
`default_nettype wire
